// *** hw/port_pkg.sv ***
// Shared constants and types for the MAC-side reduced/serial MII port
package port_pkg;
  typedef enum logic [1:0] {MODE_RMII, MODE_SMII, MODE_SSMII} mode_t;

  // Reference clock rates per interface form, in MHz
  localparam int RMII_REF_MHZ = 50;
  localparam int SMII_REF_MHZ = 125;

  // Serial segment: ten bits, last index nine; 10 Mb/s repeats each segment ten times
  localparam int SEG_BITS = 10;
  localparam logic [3:0] SEG_LAST = 4'h9;
  localparam logic [3:0] REP_LAST = 4'h9;
  // Segment field positions (receive: carrier, valid; transmit: error, enable)
  localparam int SEG_FLAG0 = 0;
  localparam int SEG_FLAG1 = 1;
  localparam int SEG_DATA_LSB = 2;

  // In-band status byte bit positions
  localparam int ST_RXER = 0;
  localparam int ST_SPEED = 1;
  localparam int ST_DUPLEX = 2;
  localparam int ST_LINK = 3;
  localparam int ST_JABBER = 4;
  localparam int ST_UPPER = 5;
  localparam int ST_FALSE = 6;
  localparam int ST_ONE = 7;

  // Controller register byte offsets
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_RXDATA = 5'h08;
  localparam logic [4:0] OFF_TXDATA = 5'h0C;
  localparam logic [4:0] OFF_INT_STAT = 5'h10;
  localparam logic [4:0] OFF_INT_MASK = 5'h14;
  // Control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TX_GO = 2;
  localparam int CTRL_TX_ERR = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Status fields
  localparam int STAT_RX_FULL = 8;
  localparam int STAT_TX_PEND = 9;
  localparam int STAT_RX_ACTIVE = 10;
  localparam int STAT_SPEED = 11;
  // Interrupt event bits
  localparam int EV_RX_BYTE = 0;
  localparam int EV_FRAME_END = 1;
  localparam int EV_COLLISION = 2;
  localparam int EV_STATUS = 3;
  localparam int EV_OVERRUN = 4;
  localparam int NUM_EV = 5;
endpackage : port_pkg

// *** hw/mac_port_if.sv ***
// Link wires between the transceiver port and the MAC
`timescale 1ns/1ps
interface mac_port_if;
  logic sync;
  logic rx_sync;
  logic crs_dv;
  logic [1:0] rxd;
  logic tx_en;
  logic [1:0] txd;

  modport phy (input sync, input tx_en, input txd, output rx_sync, output crs_dv, output rxd);
  modport mac (output sync, output tx_en, output txd, input rx_sync, input crs_dv, input rxd);
endinterface : mac_port_if

// *** hw/phy_mac_port.sv ***
// Transceiver end of the MAC-side port: strap select, elastic buffer, RMII and serial MII
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// [R1] Interface form chosen by two select pins
// [R2] Undriven select pins give reduced MII
// [R3] One shared reference clock for both directions
// [R4] Received nibbles pass through elastic buffer
// [R5] Combined carrier/valid high during packet data
// [R6] After carrier drop, carrier/valid toggles per nibble
// [R7] MAC makes sync pulse every ten clocks
// [R8] Segment per byte, repeated ten times at 10M
// [R9] Carrier, valid, then data or status bits
// [R10] Valid segment carries one byte, two nibbles
// [R11] Two-bit paths in RMII, one bit serial
// [R12] MAC transmit segment: error, enable, eight bits
// [R13] No collision signal; MAC detects it
// [R14] Nibble as two di-bits, lower first
module phy_mac_port #(
  parameter int BUF_DEPTH = 8,
  parameter int START_LEVEL = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] mode_pins_i,
  input wire logic mode_pins_driven_i,
  input wire logic rx_crs_i,
  input wire logic rx_nib_valid_i,
  input wire logic [3:0] rx_nib_i,
  input wire logic rx_er_i,
  input wire logic speed100_i,
  input wire logic full_duplex_i,
  input wire logic link_up_i,
  input wire logic jabber_i,
  input wire logic false_carrier_i,
  output port_pkg::mode_t mode_o,
  output logic tx_en_o,
  output logic tx_er_o,
  output logic tx_nib_valid_o,
  output logic [3:0] tx_nib_o,
  mac_port_if.phy link
);
  localparam int PW = $clog2(BUF_DEPTH);

  // Strap capture after reset release
  port_pkg::mode_t mode_q, mode_d;
  logic strap_done_q;

  always_comb
  begin
    mode_d = mode_q;
    if (!strap_done_q)
    begin
      if (!mode_pins_driven_i)
        mode_d = port_pkg::MODE_RMII; // [R2]
      else if (mode_pins_i[1])
        mode_d = port_pkg::MODE_RMII; // [R1]
      else if (mode_pins_i[0])
        mode_d = port_pkg::MODE_SSMII; // [R1]
      else
        mode_d = port_pkg::MODE_SMII; // [R1]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      mode_q <= port_pkg::MODE_RMII;
      strap_done_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      strap_done_q <= 1'b1;
    end

  // Receive: elastic buffer, RMII di-bit pacing, serial segments
  logic [3:0] buf_mem [BUF_DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d, rd_next;
  logic [PW:0] cnt_q, cnt_d, avail;
  logic push;
  logic [1:0] npop;
  logic run_q, run_d, phase_q, phase_d;
  logic crs_dv_q, crs_dv_d, rx_sync_q, rx_sync_d;
  logic [1:0] rxd_q, rxd_d;
  logic [3:0] scnt_q, scnt_d, rep_q, rep_d;
  logic [9:0] seg_q, seg_d;
  logic [7:0] status;
  logic crs_prev_q, er_cur_q, er_cur_d, er_prev_q, er_prev_d, half_q, half_d;
  logic [3:0] head, head2;

  assign rd_next = PW'(rd_q + PW'(1));
  assign head = buf_mem[rd_q];
  assign head2 = buf_mem[rd_next];
  // The buffer absorbs recovered-clock jitter against the reference clock
  assign push = rx_nib_valid_i && (cnt_q != (PW+1)'(BUF_DEPTH)); // [R4]

  always_comb
  begin
    status = 8'h00;
    status[port_pkg::ST_RXER] = er_prev_q; // [R9]
    status[port_pkg::ST_SPEED] = speed100_i;
    status[port_pkg::ST_DUPLEX] = full_duplex_i;
    status[port_pkg::ST_LINK] = link_up_i;
    status[port_pkg::ST_JABBER] = jabber_i;
    status[port_pkg::ST_UPPER] = !half_q;
    status[port_pkg::ST_FALSE] = false_carrier_i;
    status[port_pkg::ST_ONE] = 1'b1;
  end

  always_comb
  begin
    npop = 2'd0;
    run_d = 1'b0;
    phase_d = 1'b0;
    crs_dv_d = 1'b0;
    rxd_d = 2'b00;
    rx_sync_d = 1'b0;
    scnt_d = scnt_q;
    rep_d = rep_q;
    seg_d = seg_q;
    half_d = half_q;
    avail = cnt_q;
    er_cur_d = (crs_prev_q && er_cur_q) || (rx_er_i && rx_crs_i);
    er_prev_d = (crs_prev_q && !rx_crs_i) ? er_cur_q : er_prev_q;
    if (rx_crs_i && !crs_prev_q)
      half_d = 1'b0;
    if (mode_q == port_pkg::MODE_RMII)
    begin
      if (run_q && !phase_q)
      begin
        run_d = 1'b1;
        phase_d = 1'b1;
        rxd_d = head[3:2]; // [R14]
        crs_dv_d = 1'b1; // [R6]
      end
      else
      begin
        if (run_q)
          npop = 2'd1;
        avail = (PW+1)'(cnt_q - {{PW{1'b0}}, run_q});
        if (avail != '0 && (run_q || avail >= (PW+1)'(START_LEVEL) || !rx_crs_i))
        begin
          run_d = 1'b1;
          rxd_d = run_q ? head2[1:0] : head[1:0]; // [R14]
          crs_dv_d = rx_crs_i; // [R5] [R6]
        end
      end
    end
    else
    begin
      if (mode_q == port_pkg::MODE_SMII && link.sync)
        scnt_d = 4'h1; // [R7]
      else
        scnt_d = (scnt_q == port_pkg::SEG_LAST) ? 4'h0 : 4'(scnt_q + 4'h1);
      if (scnt_d == 4'h0)
      begin
        rep_d = (speed100_i || rep_q == port_pkg::REP_LAST) ? 4'h0 : 4'(rep_q + 4'h1); // [R8]
        if (rep_d == 4'h0)
        begin
          if (cnt_q >= (PW+1)'(2))
          begin
            npop = 2'd2;
            seg_d = {head2, head, 1'b1, rx_crs_i}; // [R9] [R10]
          end
          else if (cnt_q == (PW+1)'(1) && !rx_crs_i)
          begin
            // Odd trailing nibble goes out alone; status flags the upper half
            npop = 2'd1;
            half_d = 1'b1;
            seg_d = {4'h0, head, 1'b1, rx_crs_i};
          end
          else
            seg_d = {status, 1'b0, rx_crs_i}; // [R9]
        end
      end
      rxd_d = {1'b0, seg_d[scnt_d]}; // [R11]
      rx_sync_d = (mode_q == port_pkg::MODE_SSMII) && (scnt_d == 4'h0);
    end
    wr_d = push ? PW'(wr_q + PW'(1)) : wr_q;
    rd_d = PW'(rd_q + PW'(npop));
    cnt_d = (PW+1)'(cnt_q + {{PW{1'b0}}, push} - (PW+1)'(npop));
  end

  always_ff @(posedge ref_clk_i)
    if (push)
      buf_mem[wr_q] <= rx_nib_i; // [R4]

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      run_q <= 1'b0;
      phase_q <= 1'b0;
      crs_dv_q <= 1'b0;
      rxd_q <= 2'b00;
      rx_sync_q <= 1'b0;
      scnt_q <= 4'h0;
      rep_q <= 4'h0;
      seg_q <= 10'h000;
      crs_prev_q <= 1'b0;
      er_cur_q <= 1'b0;
      er_prev_q <= 1'b0;
      half_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      phase_q <= phase_d;
      crs_dv_q <= crs_dv_d;
      rxd_q <= rxd_d;
      rx_sync_q <= rx_sync_d;
      scnt_q <= scnt_d;
      rep_q <= rep_d;
      seg_q <= seg_d;
      crs_prev_q <= rx_crs_i;
      er_cur_q <= er_cur_d;
      er_prev_q <= er_prev_d;
      half_q <= half_d;
    end

  // No collision output exists: the MAC compares carrier with its own enable
  assign link.crs_dv = crs_dv_q; // [R13]
  assign link.rxd = rxd_q; // [R3]
  assign link.rx_sync = rx_sync_q;
  assign mode_o = mode_q;

  // Transmit: di-bit pairing or serial segment capture
  logic tph_q, tph_d;
  logic [1:0] tlo_q, tlo_d;
  logic [3:0] tcnt_q, tcnt_d, tidx, trep_q, trep_d, trep_eff;
  logic [8:0] tseg_q, tseg_d;
  logic [9:0] tfull;
  logic ten_prev_q, ten_prev_d, hi_pend_q, hi_pend_d;
  logic [3:0] hi_q, hi_d;
  logic tx_en_d, tx_er_d, tx_nv_d;
  logic [3:0] tx_nib_d;

  always_comb
  begin
    tph_d = 1'b0;
    tlo_d = tlo_q;
    tseg_d = tseg_q;
    trep_d = trep_q;
    ten_prev_d = ten_prev_q;
    hi_pend_d = 1'b0;
    hi_d = hi_q;
    tx_en_d = tx_en_o;
    tx_er_d = tx_er_o;
    tx_nv_d = hi_pend_q;
    tx_nib_d = hi_q;
    tfull = {link.txd[0], tseg_q};
    trep_eff = trep_q;
    tidx = (mode_q != port_pkg::MODE_RMII && link.sync) ? 4'h0 : tcnt_q; // [R7]
    tcnt_d = (tidx == port_pkg::SEG_LAST) ? 4'h0 : 4'(tidx + 4'h1);
    if (mode_q == port_pkg::MODE_RMII)
    begin
      tx_en_d = link.tx_en; // [R11]
      tx_er_d = 1'b0;
      tx_nv_d = 1'b0;
      if (link.tx_en)
      begin
        tph_d = !tph_q;
        if (!tph_q)
          tlo_d = link.txd; // [R14]
        else
        begin
          tx_nv_d = 1'b1;
          tx_nib_d = {link.txd, tlo_q}; // [R14]
        end
      end
    end
    else
    begin
      tseg_d[tidx] = link.txd[0]; // [R11]
      if (tidx == port_pkg::SEG_LAST)
      begin
        if (tfull[port_pkg::SEG_FLAG1] && !ten_prev_q)
          trep_eff = 4'h0;
        trep_d = (trep_eff == port_pkg::REP_LAST) ? 4'h0 : 4'(trep_eff + 4'h1);
        ten_prev_d = tfull[port_pkg::SEG_FLAG1];
        if (speed100_i || trep_eff == 4'h0) // [R8]
        begin
          tx_er_d = tfull[port_pkg::SEG_FLAG0]; // [R12]
          tx_en_d = tfull[port_pkg::SEG_FLAG1]; // [R12]
          if (tfull[port_pkg::SEG_FLAG1])
          begin
            tx_nv_d = 1'b1;
            tx_nib_d = tfull[port_pkg::SEG_DATA_LSB +: 4];
            hi_pend_d = 1'b1;
            hi_d = tfull[port_pkg::SEG_DATA_LSB+4 +: 4];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      tph_q <= 1'b0;
      tlo_q <= 2'b00;
      tcnt_q <= 4'h0;
      trep_q <= 4'h0;
      tseg_q <= 9'h000;
      ten_prev_q <= 1'b0;
      hi_pend_q <= 1'b0;
      hi_q <= 4'h0;
      tx_en_o <= 1'b0;
      tx_er_o <= 1'b0;
      tx_nib_valid_o <= 1'b0;
      tx_nib_o <= 4'h0;
    end
    else
    begin
      tph_q <= tph_d;
      tlo_q <= tlo_d;
      tcnt_q <= tcnt_d;
      trep_q <= trep_d;
      tseg_q <= tseg_d;
      ten_prev_q <= ten_prev_d;
      hi_pend_q <= hi_pend_d;
      hi_q <= hi_d;
      tx_en_o <= tx_en_d;
      tx_er_o <= tx_er_d;
      tx_nib_valid_o <= tx_nv_d;
      tx_nib_o <= tx_nib_d;
    end
endmodule : phy_mac_port

// *** hw/mac_ctrl_port.sv ***
// MAC end of the port: Avalon-MM registers, sync generation, segment and di-bit framing
`timescale 1ns/1ps
module mac_ctrl_port (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  mac_port_if.mac link
);
  port_pkg::mode_t mode;
  logic [3:0] ctrl_q, ctrl_d;
  logic [port_pkg::NUM_EV-1:0] ist_q, ist_d, imask_q, imask_d, ev;
  logic [7:0] st_q, st_d, rxb_q, rxb_d, txb_q, txb_d;
  logic rxfull_q, rxfull_d, pend_q, pend_d, spd_q, spd_d;
  logic [31:0] rdata_d;
  logic acc, take, wr_tx, pop_tx, tx_go;

  assign mode = (ctrl_q[1:0] == 2'b01) ? port_pkg::MODE_SMII :
                (ctrl_q[1:0] == 2'b10) ? port_pkg::MODE_SSMII : port_pkg::MODE_RMII;
  assign tx_go = ctrl_q[port_pkg::CTRL_TX_GO];
  // Waitrequest drops for exactly one cycle per request; read data are set up with it
  assign acc = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  assign take = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  assign wr_tx = take && avs_write_i && avs_address_i == port_pkg::OFF_TXDATA;

  // Receive deframing
  logic on_q, on_d, mph_q, mph_d, nhalf_q, nhalf_d, rdv_prev_q, rdv_prev_d, rcrs_q, rcrs_d;
  logic [1:0] lo_q, lo_d;
  logic [3:0] nlo_q, nlo_d, nib, rcnt_q, rcnt_d, ridx, rrep_q, rrep_d, rrep_eff;
  logic [8:0] rseg_q, rseg_d;
  logic [9:0] rfull;
  logic nib_v, byte_v;
  logic [7:0] byte_in;
  // Transmit framing
  logic [3:0] mcnt_q, mcnt_d, mrep_q, mrep_d, tdib_q, tdib_d;
  logic [9:0] tseg_q, tseg_d;
  logic [7:0] tsh_q, tsh_d;
  logic sync_q, sync_d, ten_q, ten_d;
  logic [1:0] txd_q, txd_d;

  always_comb
  begin
    on_d = on_q;
    mph_d = mph_q;
    lo_d = lo_q;
    nlo_d = nlo_q;
    nhalf_d = nhalf_q;
    rseg_d = rseg_q;
    rrep_d = rrep_q;
    rdv_prev_d = rdv_prev_q;
    rcrs_d = rcrs_q;
    st_d = st_q;
    spd_d = spd_q;
    nib_v = 1'b0;
    nib = {link.rxd, lo_q};
    byte_v = 1'b0;
    byte_in = {nib, nlo_q};
    ev = '0;
    rfull = {link.rxd[0], rseg_q};
    rrep_eff = rrep_q;
    ridx = ((mode == port_pkg::MODE_SMII) ? sync_q : link.rx_sync) ? 4'h0 : rcnt_q;
    rcnt_d = (ridx == port_pkg::SEG_LAST) ? 4'h0 : 4'(ridx + 4'h1);
    if (mode == port_pkg::MODE_RMII)
    begin
      rcrs_d = link.crs_dv;
      if (!on_q || !mph_q)
      begin
        on_d = on_q || link.crs_dv;
        mph_d = on_q || link.crs_dv;
        lo_d = link.rxd;
      end
      else if (!link.crs_dv)
      begin
        on_d = 1'b0;
        mph_d = 1'b0;
        nhalf_d = 1'b0;
        ev[port_pkg::EV_FRAME_END] = 1'b1;
      end
      else
      begin
        mph_d = 1'b0;
        nib_v = 1'b1;
      end
      if (nib_v)
      begin
        nhalf_d = !nhalf_q;
        nlo_d = nib;
        byte_v = nhalf_q;
      end
    end
    else
    begin
      rseg_d[ridx] = link.rxd[0];
      if (ridx == port_pkg::SEG_LAST)
      begin
        rcrs_d = rfull[port_pkg::SEG_FLAG0];
        rdv_prev_d = rfull[port_pkg::SEG_FLAG1];
        byte_in = rfull[port_pkg::SEG_DATA_LSB +: 8];
        if (rfull[port_pkg::SEG_FLAG1])
        begin
          if (!rdv_prev_q)
            rrep_eff = 4'h0;
          rrep_d = (rrep_eff == port_pkg::REP_LAST) ? 4'h0 : 4'(rrep_eff + 4'h1);
          byte_v = spd_q || rrep_eff == 4'h0;
        end
        else
        begin
          ev[port_pkg::EV_FRAME_END] = rdv_prev_q;
          ev[port_pkg::EV_STATUS] = (byte_in != st_q);
          st_d = byte_in;
          spd_d = byte_in[port_pkg::ST_SPEED];
        end
      end
    end
    ev[port_pkg::EV_RX_BYTE] = byte_v;
    ev[port_pkg::EV_OVERRUN] = byte_v && rxfull_q;
    ev[port_pkg::EV_COLLISION] = rcrs_q && ten_q; // [R13]
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    ist_d = ist_q | ev;
    txb_d = wr_tx ? avs_writedata_i[7:0] : txb_q;
    rxb_d = byte_v ? byte_in : rxb_q;
    rxfull_d = byte_v || (rxfull_q && !(take && avs_read_i && avs_address_i == port_pkg::OFF_RXDATA));
    rdata_d = 32'h0000_0000;
    if (take && avs_write_i)
      case (avs_address_i)
        port_pkg::OFF_CTRL: ctrl_d = avs_writedata_i[3:0];
        port_pkg::OFF_INT_STAT: ist_d = (ist_q & ~avs_writedata_i[port_pkg::NUM_EV-1:0]) | ev;
        port_pkg::OFF_INT_MASK: imask_d = avs_writedata_i[port_pkg::NUM_EV-1:0];
        default: ctrl_d = ctrl_q;
      endcase
    if (acc && avs_read_i)
      case (avs_address_i)
        port_pkg::OFF_CTRL: rdata_d = {28'h0, ctrl_q};
        port_pkg::OFF_STATUS: rdata_d = {20'h0, spd_q, on_q || rcrs_q, pend_q, rxfull_q, st_q};
        port_pkg::OFF_RXDATA: rdata_d = {24'h0, rxb_q};
        port_pkg::OFF_INT_STAT: rdata_d = {27'h0, ist_q};
        port_pkg::OFF_INT_MASK: rdata_d = {27'h0, imask_q};
        default: rdata_d = 32'h0000_0000;
      endcase
  end

  always_comb
  begin
    mcnt_d = (mcnt_q == port_pkg::SEG_LAST) ? 4'h0 : 4'(mcnt_q + 4'h1);
    sync_d = (mode != port_pkg::MODE_RMII) && (mcnt_d == 4'h0); // [R7]
    mrep_d = mrep_q;
    tseg_d = tseg_q;
    tdib_d = tdib_q;
    tsh_d = tsh_q;
    pop_tx = 1'b0;
    ten_d = 1'b0;
    txd_d = 2'b00;
    if (mode == port_pkg::MODE_RMII)
    begin
      if (tx_go)
      begin
        ten_d = 1'b1;
        if (!ten_q || tdib_q == 4'h3)
        begin
          pop_tx = pend_q;
          tdib_d = 4'h0;
          tsh_d = pend_q ? txb_q : 8'h00;
        end
        else
          tdib_d = 4'(tdib_q + 4'h1);
        txd_d = tsh_d[{tdib_d[1:0], 1'b0} +: 2];
      end
    end
    else
    begin
      ten_d = tx_go && pend_q;
      if (mcnt_d == 4'h0)
      begin
        mrep_d = (spd_q || mrep_q == port_pkg::REP_LAST) ? 4'h0 : 4'(mrep_q + 4'h1);
        if (mrep_d == 4'h0)
        begin
          pop_tx = tx_go && pend_q;
          tseg_d = {pop_tx ? txb_q : 8'h00, pop_tx, ctrl_q[port_pkg::CTRL_TX_ERR]}; // [R12]
        end
      end
      ten_d = tseg_d[port_pkg::SEG_FLAG1];
      txd_d = {1'b0, tseg_d[mcnt_d]};
    end
    pend_d = wr_tx || (pend_q && !pop_tx);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      ctrl_q <= port_pkg::CTRL_RESET;
      imask_q <= '0;
      ist_q <= '0;
      st_q <= 8'h00;
      rxb_q <= 8'h00;
      txb_q <= 8'h00;
      rxfull_q <= 1'b0;
      pend_q <= 1'b0;
      spd_q <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      irq_o <= 1'b0;
      on_q <= 1'b0;
      mph_q <= 1'b0;
      lo_q <= 2'b00;
      nlo_q <= 4'h0;
      nhalf_q <= 1'b0;
      rseg_q <= 9'h000;
      rcnt_q <= 4'h0;
      rrep_q <= 4'h0;
      rdv_prev_q <= 1'b0;
      rcrs_q <= 1'b0;
      mcnt_q <= 4'h0;
      mrep_q <= 4'h0;
      tseg_q <= 10'h000;
      tdib_q <= 4'h0;
      tsh_q <= 8'h00;
      sync_q <= 1'b0;
      ten_q <= 1'b0;
      txd_q <= 2'b00;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      ist_q <= ist_d;
      st_q <= st_d;
      rxb_q <= rxb_d;
      txb_q <= txb_d;
      rxfull_q <= rxfull_d;
      pend_q <= pend_d;
      spd_q <= spd_d;
      avs_readdata_o <= rdata_d;
      avs_waitrequest_o <= !acc;
      irq_o <= |(ist_d & imask_d);
      on_q <= on_d;
      mph_q <= mph_d;
      lo_q <= lo_d;
      nlo_q <= nlo_d;
      nhalf_q <= nhalf_d;
      rseg_q <= rseg_d;
      rcnt_q <= rcnt_d;
      rrep_q <= rrep_d;
      rdv_prev_q <= rdv_prev_d;
      rcrs_q <= rcrs_d;
      mcnt_q <= mcnt_d;
      mrep_q <= mrep_d;
      tseg_q <= tseg_d;
      tdib_q <= tdib_d;
      tsh_q <= tsh_d;
      sync_q <= sync_d;
      ten_q <= ten_d;
      txd_q <= txd_d;
    end

  assign link.sync = sync_q;
  assign link.tx_en = ten_q;
  assign link.txd = txd_q;
endmodule : mac_ctrl_port

// *** sim/port_chk.sv ***
// Assertions on the wires between the transceiver end and the MAC end
`timescale 1ns/1ps
module port_chk (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic sync,
  input wire logic rx_sync,
  input wire logic crs_dv,
  input wire logic [1:0] rxd,
  input wire logic tx_en,
  input wire logic [1:0] txd
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sync_period_a: assert property (sync |-> ##10 sync)
    else $error("sync not repeated after ten clocks");
  sync_gap_a: assert property (sync |=> !sync [*8])
    else $error("sync pulses too close");
  rx_sync_period_a: assert property (rx_sync |-> ##10 rx_sync)
    else $error("receive sync not repeated after ten clocks");
  serial_lines_a: assert property (sync |-> !crs_dv && !rxd[1])
    else $error("two-bit receive lines busy in serial form");
  rmii_lines_a: assert property (crs_dv |-> !sync && !rx_sync)
    else $error("carrier valid seen beside sync pulses");
  status_one_a: assert property (rx_sync ##1 !rxd[0] |-> ##8 rxd[0])
    else $error("status segment last bit not one");
  tail_toggle_a: assert property ($rose(crs_dv) && $past(crs_dv, 2) |=> !crs_dv)
    else $error("carrier valid tail not toggling");
  tx_mirror_a: assert property (sync |=> txd[0] == tx_en)
    else $error("segment enable bit differs from enable line");
  cover property (sync ##1 txd[0]);
  cover property (rx_sync ##1 rxd[0]);
  cover property ($rose(crs_dv) && $past(crs_dv, 2));
endmodule : port_chk

// *** sim/reduced_serial_mii_mac_port_tb_top.sv ***
// Bench joining both port ends and driving them through registers and strap pins
`timescale 1ns/1ps
module reduced_serial_mii_mac_port_tb_top;
  logic ref_clk_i, rst_b_i, mode_pins_driven_i, rx_crs_i, rx_nib_valid_i, speed100_i;
  logic [1:0] mode_pins_i;
  logic [3:0] rx_nib_i;
  port_pkg::mode_t mode_o;
  logic tx_en_o, tx_nib_valid_o, irq_o, avs_waitrequest_o, avs_read_i, avs_write_i;
  logic [3:0] tx_nib_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rdat;
  logic [3:0] txq[$];
  int err_count, tests_run, cyc;
  mac_port_if link_if();
  phy_mac_port phy_mac_port_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .mode_pins_i(mode_pins_i), .mode_pins_driven_i(mode_pins_driven_i),
    .rx_crs_i(rx_crs_i), .rx_nib_valid_i(rx_nib_valid_i), .rx_nib_i(rx_nib_i),
    .rx_er_i(1'b0), .speed100_i(speed100_i), .full_duplex_i(1'b1), .link_up_i(1'b1),
    .jabber_i(1'b0), .false_carrier_i(1'b0), .mode_o(mode_o), .tx_en_o(tx_en_o),
    .tx_er_o(), .tx_nib_valid_o(tx_nib_valid_o), .tx_nib_o(tx_nib_o), .link(link_if));
  mac_ctrl_port mac_ctrl_port_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .link(link_if));
  port_chk port_chk_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sync(link_if.sync),
    .rx_sync(link_if.rx_sync), .crs_dv(link_if.crs_dv), .rxd(link_if.rxd),
    .tx_en(link_if.tx_en), .txd(link_if.txd));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Nibbles the transceiver hands on from the MAC's transmit stream
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (tx_nib_valid_o === 1'b1)
      txq.push_back(tx_nib_o);
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low, then lets one edge pass
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0)
      @(posedge ref_clk_i);
    rdat = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : acc

  task automatic irqchk(input logic e);
    @(negedge ref_clk_i);
    chk("irq", 12'(e), 12'(irq_o));
    @(posedge ref_clk_i);
  endtask : irqchk

  function automatic logic has_pair(input logic [7:0] b);
    for (int i = 0; i + 1 < txq.size(); i++)
      if (txq[i] === b[3:0] && txq[i + 1] === b[7:4])
        return 1'b1;
    return 1'b0;
  endfunction : has_pair

  task automatic frame(input logic [7:0] b, input int h, input int wt);
    rx_crs_i <= 1'b1;
    rx_nib_valid_i <= 1'b1;
    rx_nib_i <= b[3:0];
    @(posedge ref_clk_i);
    rx_nib_i <= b[7:4];
    @(posedge ref_clk_i);
    rx_nib_valid_i <= 1'b0;
    repeat (h) @(posedge ref_clk_i);
    rx_crs_i <= 1'b0;
    repeat (wt) @(posedge ref_clk_i);
  endtask : frame

  // Transmit runs during the receive frame so that a collision is seen too
  task automatic xfer(input logic [1:0] c, input logic [7:0] b, input int h, input int wt);
    // Carrier leads the transmit segment so that serial forms overlap them too
    rx_crs_i <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    acc(1'b1, port_pkg::OFF_INT_MASK, 32'h1);
    acc(1'b1, port_pkg::OFF_TXDATA, {24'h0, ~b});
    txq.delete();
    acc(1'b1, port_pkg::OFF_CTRL, {28'h0, 2'b01, c});
    frame(b, h, wt);
    acc(1'b0, port_pkg::OFF_RXDATA, 32'h0);
    chk("rx byte", 12'(b), 12'(rdat[7:0]));
    acc(1'b0, port_pkg::OFF_INT_STAT, 32'h0);
    chk("events", 12'h7, 12'(rdat[2:0]));
    irqchk(1'b1);
    acc(1'b1, port_pkg::OFF_INT_MASK, 32'h0);
    irqchk(1'b0);
    acc(1'b1, port_pkg::OFF_INT_STAT, 32'h1F);
    acc(1'b1, port_pkg::OFF_INT_MASK, 32'h7);
    acc(1'b0, port_pkg::OFF_INT_STAT, 32'h0);
    chk("events cleared", 12'h0, 12'(rdat[2:0]));
    irqchk(1'b0);
    chk("tx byte", 12'h1, 12'(has_pair(~b)));
    chk("tx enable", 12'(c == 2'h0 || c == 2'h3), 12'(tx_en_o));
    acc(1'b1, port_pkg::OFF_CTRL, {30'h0, c});
  endtask : xfer

  task automatic scen(input logic [1:0] p, input logic dr, input logic [1:0] c,
    input port_pkg::mode_t e, input logic [7:0] b, input int h, input int wt);
    rst_b_i <= 1'b0;
    mode_pins_i <= p;
    mode_pins_driven_i <= dr;
    repeat (4) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk("mode", 12'(e), 12'(mode_o));
    @(posedge ref_clk_i);
    acc(1'b0, 5'h1C, 32'h0);
    chk("unmapped", 12'h0, rdat[11:0]);
    xfer(c, b, h, wt);
  endtask : scen

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial
  begin
    {rst_b_i, rx_crs_i, rx_nib_valid_i, rx_nib_i, avs_read_i, avs_write_i} = '0;
    {mode_pins_i, mode_pins_driven_i, avs_address_i, avs_writedata_i} = '0;
    speed100_i = 1'b1;
    err_count = 0;
    tests_run = 0;
    cyc = 0;
    @(posedge ref_clk_i);
    scen(2'b10, 1'b1, 2'h0, port_pkg::MODE_RMII, 8'hA5, 1, 40);
    scen(2'b00, 1'b0, 2'h3, port_pkg::MODE_RMII, 8'h3C, 1, 40);
    scen(2'b00, 1'b1, 2'h1, port_pkg::MODE_SMII, 8'hC3, 24, 60);
    scen(2'b01, 1'b1, 2'h2, port_pkg::MODE_SSMII, 8'h69, 24, 60);
    acc(1'b0, port_pkg::OFF_STATUS, 32'h0);
    chk("status fast", 12'h88E, rdat[11:0] & 12'h8DF);
    speed100_i <= 1'b0;
    repeat (300) @(posedge ref_clk_i);
    acc(1'b0, port_pkg::OFF_STATUS, 32'h0);
    chk("status slow", 12'h08C, rdat[11:0] & 12'h8DF);
    xfer(2'h2, 8'h96, 200, 400);
    results();
  end
endmodule : reduced_serial_mii_mac_port_tb_top
